// *** common/tmr16_pkg.sv ***
// package for the cascaded 16-bit timer / pwm block
// assumes an apb slave with 32-bit data and byte addresses
package tmr16_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_LOWER_CTRL  = 8'h00;
    localparam logic [7:0] OFF_UPPER_CTRL  = 8'h04;
    localparam logic [7:0] OFF_PERIOD_LOW  = 8'h08;
    localparam logic [7:0] OFF_PERIOD_HIGH = 8'h0C;
    localparam logic [7:0] OFF_DUTY_LOW    = 8'h10;
    localparam logic [7:0] OFF_DUTY_HIGH   = 8'h14;
    localparam logic [7:0] OFF_COUNT       = 8'h18;
    localparam logic [7:0] OFF_STATUS      = 8'h1C;
    localparam logic [7:0] OFF_CONFIG      = 8'h20;
    // lower_timer_control fields
    localparam int LC_SRC_LSB  = 4;  // [6:4] source select
    localparam int LC_SRC_W    = 3;
    // upper_timer_control fields
    localparam int UC_MODE_LSB = 0;  // [1:0] mode
    localparam int UC_RUN_BIT  = 3;  // run_control_bit
    localparam int UC_FFI_BIT  = 7;  // flip_flop_init_bit
    // config register fields
    localparam int CF_PSEL_BIT = 0;  // prescaler_source_select
    localparam int CF_SLOW_BIT = 1;  // low speed run mode
    localparam int CF_EXT_BIT  = 2;  // pwm counts event pin
    // reset values
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] CMP_RST   = 16'hFFFF;
    localparam logic [15:0] DUTY_RST  = 16'h0000;
    // prescaler: main_osc_clock is ref clock, sub clock is a divided enable
    localparam int SUB_DIV = 8;
    localparam logic [10:0] MASK_11 = 11'h7FF;
    localparam logic [10:0] MASK_7  = 11'h07F;
    localparam logic [10:0] MASK_5  = 11'h01F;
    localparam logic [10:0] MASK_3  = 11'h007;
    localparam logic [10:0] MASK_1  = 11'h001;
    localparam logic [2:0]  SUB_MASK_3 = 3'h7;
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_TIMER,
        MODE_EVENT,
        MODE_PWM
    } mode_e;
endpackage

// *** common/duty_if.sv ***
// interface between the timer core and its duty buffer
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface duty_if;
    logic        wr_low;
    logic        wr_high;
    logic [7:0]  wdata;
    logic        shift;
    logic [15:0] active;
    logic [15:0] buffered;
    modport core (output wr_low, output wr_high, output wdata,
                  output shift, input active, input buffered);
    modport buf_side (input wr_low, input wr_high, input wdata,
                      input shift, output active, output buffered);
endinterface
`default_nettype wire

// *** rtl/duty_buffer.sv ***
// double-buffered duty compare storage
// shift from the core is held high while stopped and pulses for one cycle at pwm overflow
`timescale 1ns/1ps
`default_nettype none
module duty_buffer
    import tmr16_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    duty_if.buf_side  port
);
    typedef struct packed {
        logic [15:0] buffered;
        logic [15:0] active;
    } dbuf_s;
    dbuf_s st;
    dbuf_s next_st;

    // writes land in the buffer; shift moves it to the active stage
    always_comb
    begin
        next_st = st;
        if (port.wr_low)
            next_st.buffered[7:0] = port.wdata;
        if (port.wr_high)
            next_st.buffered[15:8] = port.wdata;
        if (port.shift)
            next_st.active = next_st.buffered;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            st <= {DUTY_RST, DUTY_RST};
        else
            st <= next_st;
    end

    assign port.active   = st.active;
    assign port.buffered = st.buffered;
endmodule
`default_nettype wire

// *** rtl/tmr16.sv ***
// cascaded 16-bit timer, event counter and pwm with apb registers
// assumes synchronous inputs on the 40 MHz ref clock (main_osc_clock)
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - timer mode: one 16-bit counter advances on selected prescaled clock
// - counting starts only when run bit in upper control is 1
// - timer match: raise interrupt, clear counter, keep counting
// - period compare has no shadow; writes act at once
// - event mode: count each falling edge of event pin
// - pwm counter advances on internal clock or event pin
// - pwm duty match inverts output flip-flop, counter continues
// - pwm overflow inverts flip-flop, clears counter, raises interrupt
// - flip-flop loads init bit for polarity; reset clears it
// - pwm pin drives inverse of output flip-flop
// - duty writes while running wait in buffer until pwm overflow interrupt
// - duty writes while stopped transfer immediately
// - duty read while running returns active stage value
// - stop holds pwm pin level; init bit changes after stopping
// - source choices per speed mode and prescaler select
module tmr16
    import tmr16_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic [31:0]      prdata_out,
    input  wire logic        event_in,
    output logic             pwm_out,
    output logic             match_irq_out
);
    typedef struct packed {
        logic [7:0]  lower_ctrl;
        logic [7:0]  upper_ctrl;
        logic [2:0]  cfg;
        logic [15:0] period;
        logic [15:0] count;
        logic [10:0] prescale;
        logic [2:0]  subdiv;
        logic [2:0]  subpre;
        logic        event_d;
        logic        flip;
        logic        irq;
        logic        status;
        logic [31:0] rdata;
    } core_s;
    core_s st;
    core_s next_st;
    duty_if dif ();

    logic        run;
    logic        tick;
    logic        sub_tick;
    logic        fall;
    logic        access;
    logic        wr;
    logic        pend;
    logic [1:0]  mode;
    logic [15:0] duty_rd;

    duty_buffer u_duty (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .port       (dif.buf_side)
    );

    // selected source: returns one when the divided enable fires
    function automatic logic src_tick(input logic [2:0]  sel,
                                      input logic        psel,
                                      input logic        slow,
                                      input logic [10:0] pre,
                                      input logic        sub,
                                      input logic [2:0]  spre);
        logic r;
        r = 1'b0;
        if (slow)
            r = (sel == 3'd0) ? (sub && spre == SUB_MASK_3) : sub;
        else
            case (sel)
                3'd0: r = psel ? (sub && spre == SUB_MASK_3)
                               : (pre == MASK_11);
                3'd1: r = (pre[6:0] == MASK_7[6:0]);
                3'd2: r = (pre[4:0] == MASK_5[4:0]);
                3'd3: r = (pre[2:0] == MASK_3[2:0]);
                3'd4: r = sub;
                3'd5: r = (pre[0] == MASK_1[0]);
                default: r = 1'b1;
            endcase
        return r;
    endfunction

    assign run      = st.upper_ctrl[UC_RUN_BIT];
    assign mode     = st.upper_ctrl[UC_MODE_LSB +: 2];
    assign sub_tick = (st.subdiv == 3'(SUB_DIV - 1));
    assign fall     = st.event_d && !event_in;
    assign tick     = src_tick(st.lower_ctrl[LC_SRC_LSB +: LC_SRC_W],
                               st.cfg[CF_PSEL_BIT], st.cfg[CF_SLOW_BIT],
                               st.prescale, sub_tick, st.subpre);
    // a write lands once, in the ready cycle: landing again after a stop
    // would reload the flip-flop and break the held pin level
    assign access   = psel_in && penable_in;
    assign wr       = access && pwrite_in && pend;

    // duty bytes go to the buffer; stopped timer shifts at once
    assign dif.wr_low  = wr && paddr_in == OFF_DUTY_LOW;
    assign dif.wr_high = wr && paddr_in == OFF_DUTY_HIGH;
    assign dif.wdata   = pwdata_in[7:0];
    // a running timer reads back the stage in use until the next overflow
    assign duty_rd     = run ? dif.active : dif.buffered;

    always_comb
    begin
        logic adv;
        logic ovf;
        adv = 1'b0;
        ovf = 1'b0;
        next_st = st;
        next_st.irq = 1'b0;
        // stopped, the buffer is copied every cycle, so a write acts at once
        dif.shift = !run;
        next_st.prescale = st.prescale + 11'd1;
        next_st.subdiv = sub_tick ? 3'd0 : st.subdiv + 3'd1;
        if (sub_tick)
            next_st.subpre = st.subpre + 3'd1;
        next_st.event_d = event_in;
        // count advance per mode; idle mode never counts
        if (run)
        begin
            case (mode)
                2'(MODE_TIMER): adv = tick;
                2'(MODE_EVENT): adv = fall;
                2'(MODE_PWM):   adv = st.cfg[CF_EXT_BIT] ? fall
                                                         : tick;
                default:        adv = 1'b0;
            endcase
        end
        // match is judged on the advancing tick: period n spans n + 1 ticks
        if (adv)
        begin
            if (mode == 2'(MODE_PWM))
            begin
                ovf = (st.count == 16'hFFFF);
                next_st.count = st.count + 16'd1;
                if (st.count == dif.active)
                    next_st.flip = !st.flip;
                // overflow is the one safe moment to take the new duty
                if (ovf)
                begin
                    next_st.flip  = !st.flip;
                    next_st.count = 16'h0000;
                    next_st.irq   = 1'b1;
                    dif.shift     = 1'b1;
                end
            end
            else if (st.count == st.period)
            begin
                next_st.count = 16'h0000;
                next_st.irq   = 1'b1;
            end
            else
                next_st.count = st.count + 16'd1;
        end
        if (next_st.irq)
            next_st.status = 1'b1;
        // apb writes; stop holds flip so the pin keeps its level
        if (wr)
        begin
            case (paddr_in)
                OFF_LOWER_CTRL:  next_st.lower_ctrl = pwdata_in[7:0];
                OFF_UPPER_CTRL:
                begin
                    next_st.upper_ctrl = pwdata_in[7:0];
                    // init bit loads only when written with the run bit
                    // clear and timer already stopped
                    if (!run && !pwdata_in[UC_RUN_BIT])
                        next_st.flip = pwdata_in[UC_FFI_BIT];
                end
                OFF_PERIOD_LOW:  next_st.period[7:0]  = pwdata_in[7:0];
                OFF_PERIOD_HIGH: next_st.period[15:8] = pwdata_in[7:0];
                OFF_CONFIG:      next_st.cfg = pwdata_in[2:0];
                OFF_STATUS:
                    if (pwdata_in[0] && !next_st.irq)
                        next_st.status = 1'b0;  // set wins over clear
                default: ;
            endcase
        end
        // read data registered in the access cycle
        next_st.rdata = 32'h0000_0000;
        case (paddr_in)
            OFF_LOWER_CTRL:  next_st.rdata[7:0]  = st.lower_ctrl;
            OFF_UPPER_CTRL:  next_st.rdata[7:0]  = st.upper_ctrl;
            OFF_PERIOD_LOW:  next_st.rdata[7:0]  = st.period[7:0];
            OFF_PERIOD_HIGH: next_st.rdata[7:0]  = st.period[15:8];
            OFF_DUTY_LOW:    next_st.rdata[7:0]  = duty_rd[7:0];
            OFF_DUTY_HIGH:   next_st.rdata[7:0]  = duty_rd[15:8];
            OFF_COUNT:       next_st.rdata[15:0] = st.count;
            OFF_STATUS:      next_st.rdata[1:0]  = {st.flip, st.status};
            OFF_CONFIG:      next_st.rdata[2:0]  = st.cfg;
            default:         next_st.rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            st            <= '0;
            st.lower_ctrl <= CTRL_RST;
            st.upper_ctrl <= CTRL_RST;
            st.period     <= CMP_RST;
            st.event_d    <= 1'b1;
        end
        else
            st <= next_st;
    end

    // one wait state: setup, access, then ready with registered data
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            pend <= 1'b0;
        else
            pend <= access && !pend;
    end
    assign pready_out    = pend;
    assign pslverr_out   = 1'b0;
    assign prdata_out    = st.rdata;
    assign pwm_out       = !st.flip;
    assign match_irq_out = st.irq;

    // writes land only in the ready cycle, so !wr marks a quiet cycle
    timer_clear_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_TIMER) && tick && st.count == st.period
         && !wr) |=> (st.count == 16'h0000 && match_irq_out))
        else $error("timer match did not clear");
    stop_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (!run && !wr) |=> $stable(st.count))
        else $error("counter moved while stopped");
    event_count_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_EVENT) && fall && st.count != st.period
         && !wr) |=> st.count == $past(st.count) + 16'd1)
        else $error("event edge not counted");
    pwm_pin_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in) (!run && !wr) |=> $stable(pwm_out))
        else $error("pwm pin moved while stopped");
    pwm_ovf_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_PWM) && st.count == 16'hFFFF && !wr
         && (st.cfg[CF_EXT_BIT] ? fall : tick))
        |=> (match_irq_out && st.count == 16'h0000))
        else $error("pwm overflow mishandled");
    duty_shift_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run ##1 (run && !match_irq_out)) |-> $stable(dif.active))
        else $error("duty changed without interrupt");
    duty_stop_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (!run && dif.wr_low) |=> ##1 dif.active[7:0] == $past(dif.wdata, 2))
        else $error("stopped duty write not applied");
    period_now_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (wr && paddr_in == OFF_PERIOD_LOW) |=> st.period[7:0] ==
         $past(pwdata_in[7:0]))
        else $error("period write not immediate");
    pwm_match_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_PWM) && tick && !st.cfg[CF_EXT_BIT]
         && st.count == dif.active && st.count != 16'hFFFF && !wr)
        |=> st.flip != $past(st.flip))
        else $error("duty match did not toggle");
    duty_stop_hi_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (!run && dif.wr_high) |=> ##1 dif.active[15:8] == $past(dif.wdata, 2))
        else $error("stopped duty high write not applied");
    duty_load_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_PWM) && st.count == 16'hFFFF && !wr
         && (st.cfg[CF_EXT_BIT] ? fall : tick))
        |=> dif.active == $past(dif.buffered))
        else $error("duty not loaded at overflow");
    pwm_ext_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_PWM) && st.cfg[CF_EXT_BIT] && fall
         && st.count != 16'hFFFF && !wr)
        |=> st.count == $past(st.count) + 16'd1)
        else $error("pwm missed an event edge");
    event_match_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && mode == 2'(MODE_EVENT) && fall && st.count == st.period
         && !wr) |=> (st.count == 16'h0000 && match_irq_out))
        else $error("event match did not clear");

    // reset levels, bus timing and interrupt bookkeeping
    reset_level_a: assert property (@(posedge ref_clk_in)
        sys_rst_in |=> (pwm_out && !match_irq_out))
        else $error("reset left pin or interrupt active");
    ready_pulse_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in) pready_out |=> !pready_out)
        else $error("ready held past one cycle");
    idle_irq_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in) !run |=> !match_irq_out)
        else $error("interrupt while stopped");
    status_set_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in) match_irq_out |-> st.status)
        else $error("sticky match flag missed");

    // control writes and the output flip-flop
    flip_init_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (!run && wr && paddr_in == OFF_UPPER_CTRL && !pwdata_in[UC_RUN_BIT])
        |=> st.flip == $past(pwdata_in[UC_FFI_BIT]))
        else $error("init bit not loaded while stopped");
    stop_level_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (run && wr && paddr_in == OFF_UPPER_CTRL && !pwdata_in[UC_RUN_BIT])
        |=> ##1 $stable(pwm_out))
        else $error("stop write moved the pin");

    // main scenarios
    cov_timer_c: cover property (@(posedge ref_clk_in)
        mode == 2'(MODE_TIMER) && match_irq_out);
    cov_event_c: cover property (@(posedge ref_clk_in)
        mode == 2'(MODE_EVENT) && match_irq_out);
    cov_pwm_c: cover property (@(posedge ref_clk_in)
        mode == 2'(MODE_PWM) && match_irq_out);
    cov_stop_c: cover property (@(posedge ref_clk_in)
        run ##1 !run);
    cov_ext_c: cover property (@(posedge ref_clk_in)
        mode == 2'(MODE_PWM) && st.cfg[CF_EXT_BIT] && fall);
endmodule
`default_nettype wire

// *** sim/event_source.sv ***
// pulse source model that drives the timer's event pin
// assumes the bench calls send_falls; the pin idles high between bursts
`timescale 1ns/1ps
`default_nettype none
module event_source
(
    input  wire logic ref_clk_in,
    output var logic  event_out
);
    // idle high, as a pulled-up pin sits when no source drives it
    initial event_out = 1'b1;

    // n falling edges, each level held hold cycles; holds shorter than
    // 2 cycles are stretched to 2
    task automatic send_falls(input int n, input int hold);
        int k;
        int hh;
        hh = (hold < 2) ? 2 : hold;
        for (k = 0; k < n; k++)
        begin
            repeat (hh) @(posedge ref_clk_in);
            event_out <= 1'b0;
            repeat (hh) @(posedge ref_clk_in);
            event_out <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the cascaded 16-bit timer and pwm block
// assumes one apb wait state and a 40 MHz reference clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tmr16_pkg::*;
    typedef struct packed {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [2:0]  src;
        logic [11:0] div;
    } clk_row_s;
    // register reads after reset, then writes with read-back
    localparam row_s ROWS [13] = '{
        '{1'b0, OFF_LOWER_CTRL, 8'h00, 8'h00},
        '{1'b0, OFF_UPPER_CTRL, 8'h00, 8'h00},
        '{1'b0, OFF_PERIOD_LOW, 8'h00, 8'hFF},
        '{1'b0, OFF_PERIOD_HIGH, 8'h00, 8'hFF},
        '{1'b0, OFF_DUTY_LOW, 8'h00, 8'h00},
        '{1'b0, OFF_DUTY_HIGH, 8'h00, 8'h00},
        '{1'b0, OFF_COUNT, 8'h00, 8'h00},
        '{1'b0, OFF_STATUS, 8'h00, 8'h00},
        '{1'b0, OFF_CONFIG, 8'h00, 8'h00},
        '{1'b1, 8'h24, 8'h55, 8'h00},
        '{1'b1, OFF_PERIOD_LOW, 8'h5A, 8'h5A},
        '{1'b1, OFF_DUTY_HIGH, 8'hA5, 8'hA5},
        '{1'b1, OFF_LOWER_CTRL, 8'h60, 8'h60}};
    // source select against ticks per count
    localparam clk_row_s CLKS [8] = '{
        '{8'h00, 3'h3, 12'h008}, '{8'h00, 3'h5, 12'h002},
        '{8'h00, 3'h6, 12'h001}, '{8'h00, 3'h2, 12'h020},
        '{8'h00, 3'h1, 12'h080}, '{8'h00, 3'h4, 12'h008},
        '{8'h01, 3'h0, 12'h040}, '{8'h02, 3'h0, 12'h040}};
    logic        ref_clk_in;
    logic        sys_rst_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        event_line;
    logic        pwm;
    logic        irq;
    logic [31:0] rd;
    int          fail_count;
    int          cmp_count;
    int          irq_seen;
    int          n;

    initial
    begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    tmr16 dut
    (
        .ref_clk_in    (ref_clk_in),
        .sys_rst_in    (sys_rst_in),
        .psel_in       (psel),
        .penable_in    (penable),
        .pwrite_in     (pwrite),
        .paddr_in      (paddr),
        .pwdata_in     (pwdata),
        .pready_out    (pready),
        .pslverr_out   (),
        .prdata_out    (prdata),
        .event_in      (event_line),
        .pwm_out       (pwm),
        .match_irq_out (irq)
    );

    event_source src
    (
        .ref_clk_in (ref_clk_in),
        .event_out  (event_line)
    );

    // interrupt pulses seen, for the event count scenario
    always @(posedge ref_clk_in)
        if (irq === 1'b1)
            irq_seen++;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp,
                     seen);
        end
    endtask

    // one apb transfer; the request stands until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge ref_clk_in);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        check("pready", {31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    // sel 0 waits for an interrupt pulse, sel 1 for the pwm pin low
    task automatic wait_for(input int sel, input int lim, output int c);
        for (c = 1; c <= lim; c++)
        begin
            @(posedge ref_clk_in);
            if ((sel == 0) ? (irq === 1'b1) : (pwm === 1'b0))
                break;
        end
        check("wait", {31'h0, c <= lim}, 32'h1);
    endtask

    task automatic do_reset();
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // longest path is one full pwm period of 65536 counts
    initial
    begin
        repeat (90000) @(posedge ref_clk_in);
        check("watchdog", 32'h0, 32'h1);
        close_out();
    end

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sys_rst_in = 1'b1;
        do_reset();
        check("pwm rst", {31'h0, pwm}, 32'h1);
        check("irq rst", {31'h0, irq}, 32'h0);
        $display("test reset done");
        foreach (ROWS[i])
        begin
            if (ROWS[i].w)
                wr(ROWS[i].a, {24'h0, ROWS[i].d});
            apb(1'b0, ROWS[i].a, 32'h0, rd);
            check("reg", {24'h0, rd[7:0]}, {24'h0, ROWS[i].e});
        end
        $display("test registers done");
        foreach (CLKS[i])
        begin
            do_reset();
            wr(OFF_CONFIG, {24'h0, CLKS[i].cfg});
            wr(OFF_PERIOD_LOW, 32'h5);
            wr(OFF_PERIOD_HIGH, 32'h0);
            wr(OFF_LOWER_CTRL, {25'h0, CLKS[i].src, 4'h0});
            wr(OFF_UPPER_CTRL, 32'h9);
            wait_for(0, 2000, n);
            wait_for(0, 2000, n);
            check("src gap", n, 6 * CLKS[i].div);
        end
        $display("test sources done");
        do_reset();
        wr(OFF_PERIOD_LOW, 32'h5);
        wr(OFF_PERIOD_HIGH, 32'h0);
        wr(OFF_LOWER_CTRL, 32'h60);
        wr(OFF_UPPER_CTRL, 32'h1);
        repeat (30) @(posedge ref_clk_in);
        apb(1'b0, OFF_COUNT, 32'h0, rd);
        check("idle count", rd, 32'h0);
        wr(OFF_UPPER_CTRL, 32'h9);
        wait_for(0, 100, n);
        wait_for(0, 100, n);
        check("timer gap", n, 6);
        // rewrite just after a match so the count is still small
        wr(OFF_PERIOD_LOW, 32'h0);
        wr(OFF_PERIOD_HIGH, 32'h1);
        wait_for(0, 400, n);
        wait_for(0, 400, n);
        check("new period", n, 257);
        $display("test timer done");
        do_reset();
        wr(OFF_PERIOD_LOW, 32'h3);
        wr(OFF_PERIOD_HIGH, 32'h0);
        wr(OFF_UPPER_CTRL, 32'hA);
        irq_seen = 0;
        src.send_falls(2, 3);
        repeat (4) @(posedge ref_clk_in);
        apb(1'b0, OFF_COUNT, 32'h0, rd);
        check("events", rd, 32'h2);
        src.send_falls(3, 3);
        repeat (4) @(posedge ref_clk_in);
        apb(1'b0, OFF_COUNT, 32'h0, rd);
        check("event wrap", rd, 32'h1);
        check("event irqs", irq_seen, 32'h1);
        $display("test events done");
        do_reset();
        wr(OFF_LOWER_CTRL, 32'h60);
        wr(OFF_DUTY_LOW, 32'h10);
        wr(OFF_DUTY_HIGH, 32'h0);
        wr(OFF_UPPER_CTRL, 32'hB);
        wait_for(1, 100, n);
        check("duty pos", {31'h0, n >= 12 && n <= 20}, 32'h1);
        wr(OFF_DUTY_LOW, 32'h40);
        wr(OFF_DUTY_HIGH, 32'h0);
        apb(1'b0, OFF_DUTY_LOW, 32'h0, rd);
        check("duty held", rd, 32'h10);
        wait_for(0, 70000, n);
        check("pwm ovf", {31'h0, pwm}, 32'h1);
        wait_for(1, 200, n);
        check("new duty", {31'h0, n >= 62 && n <= 66}, 32'h1);
        apb(1'b0, OFF_DUTY_LOW, 32'h0, rd);
        check("duty read", rd, 32'h40);
        wr(OFF_UPPER_CTRL, 32'h3);
        repeat (100) @(posedge ref_clk_in);
        check("pwm held", {31'h0, pwm}, 32'h0);
        wr(OFF_UPPER_CTRL, 32'h3);
        repeat (3) @(posedge ref_clk_in);
        check("init 0", {31'h0, pwm}, 32'h1);
        wr(OFF_UPPER_CTRL, 32'h83);
        repeat (3) @(posedge ref_clk_in);
        check("init 1", {31'h0, pwm}, 32'h0);
        // pwm clocked from the event pin: third edge meets duty 2
        do_reset();
        wr(OFF_CONFIG, 32'h4);
        wr(OFF_DUTY_LOW, 32'h2);
        wr(OFF_DUTY_HIGH, 32'h0);
        wr(OFF_UPPER_CTRL, 32'hB);
        src.send_falls(3, 2);
        repeat (4) @(posedge ref_clk_in);
        apb(1'b0, OFF_COUNT, 32'h0, rd);
        check("ext count", rd, 32'h3);
        check("ext duty", {31'h0, pwm}, 32'h0);
        $display("test pwm done");
        close_out();
    end
endmodule
`default_nettype wire
